// >>> rtl/iaf_pkg.sv
// Shared constants and types of the flash mailbox sequencer.
package iaf_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] ADDRL_OFS  = 8'h08;
  localparam logic [7:0] ADDRH_OFS  = 8'h0C;
  localparam logic [7:0] DATA_OFS   = 8'h10;
  localparam logic [7:0] CONFIG_OFS = 8'h14;
  // Values after reset.
  localparam logic [7:0] REG_RST    = 8'h00;
  // Field positions.
  localparam int CFG_ENABLE_BIT   = 6;
  localparam int CFG_BANK_LSB     = 0;
  localparam int STAT_BUSY_BIT    = 2;
  localparam int STAT_REFUSED_BIT = 0;
  localparam int CMD_IRQ_BIT      = 7;
  // Command codes in bits 6:0 of the command byte.
  localparam logic [6:0] CMD_CHIP_ERASE   = 7'h01;
  localparam logic [6:0] CMD_BLOCK_ERASE  = 7'h0D;
  localparam logic [6:0] CMD_SECTOR_ERASE = 7'h0B;
  localparam logic [6:0] CMD_BYTE_PROG    = 7'h0E;
  localparam logic [6:0] CMD_IDENTIFY     = 7'h0F;
  // Address map of the two blocks and of the signature bytes.
  localparam logic [15:0] BLOCK1_LIMIT    = 16'h2000;
  localparam logic [15:0] BLOCK1_PROBE    = 16'h0000;
  localparam logic [7:0]  SIG_MAKER_ADDR  = 8'h30;
  localparam logic [7:0]  SIG_PART_ADDR   = 8'h31;
  localparam logic [7:0]  SIG_BLANK       = 8'hFF;
  localparam int          SECTOR_BITS     = 7;
  // Flash array operations.
  typedef enum logic [2:0] {OP_NONE, OP_CHIP, OP_BLOCK, OP_SECTOR, OP_PROG} iaf_op_e;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_IDENT} iaf_state_e;
  // Request handed to the flash array.
  typedef struct packed {
    iaf_op_e     op;
    logic        blk;
    logic [15:0] addr;
    logic [7:0]  data;
  } iaf_flash_req_s;
endpackage

// >>> rtl/iaf_target_resolve.sv
// Resolves the originating and targeted flash block of a mailbox command.
`timescale 1ns/10ps
`default_nettype none
module iaf_target_resolve (
  // Fetch context.
  input  wire logic        strap,
  input  wire logic        fetch_external,
  input  wire logic [15:0] fetch_pc,
  input  wire logic [1:0]  bank_sel,
  // Requested address and result.
  input  wire logic [15:0] target_addr,
  output logic             target_blk,
  output logic             no_op
);
  // Fetches count as external when the strap forbids internal code.
  wire ext_code   = ~strap | fetch_external;
  wire bank_zero  = (bank_sel == 2'h0);
  wire pc_low     = (fetch_pc < iaf_pkg::BLOCK1_LIMIT);
  wire tgt_low    = (target_addr < iaf_pkg::BLOCK1_LIMIT);
  // Origin follows visibility, so hidden code can never be an origin.
  wire origin_blk = bank_zero & pc_low;
  // External code picks by address under bank zero, else always Block 0.
  wire ext_blk    = bank_zero & tgt_low;
  // Internal code targets the other block; high targets from Block 0 do nothing.
  wire int_blk    = ~origin_blk;
  wire int_none   = ~origin_blk & ~tgt_low;
  assign target_blk = ext_code ? ext_blk : int_blk;
  assign no_op      = ~ext_code & int_none;
endmodule
`default_nettype wire

// >>> rtl/iaf_sig_rom.sv
// Signature byte store with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module iaf_sig_rom #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] PART_CODE  = 8'hA5  // Arbitrary value.
) (
  // Clock, reset and clock enable.
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Read port.
  input  wire logic       rd_en,
  input  wire logic [7:0] addr,
  output logic [7:0]      rd_data
);
  // Address decode of the two signature bytes.
  wire [7:0] sig_byte = (addr == iaf_pkg::SIG_MAKER_ADDR) ? MAKER_CODE :
                        (addr == iaf_pkg::SIG_PART_ADDR)  ? PART_CODE  :
                        iaf_pkg::SIG_BLANK;
  // Read data comes out of a register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data <= iaf_pkg::REG_RST;
    else if (ce && rd_en)
      rd_data <= sig_byte;
  end
endmodule
`default_nettype wire

// >>> rtl/iaf_mailbox.sv
// Mailbox register file and operation sequencer for the two-block flash.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Erase and program commands are ignored while the enable bit 6 is clear.
// - Writing the command byte starts the operation using the loaded mailbox values.
// - Commands other than chip erase aimed at a locked block are refused.
// - The originating block is never written; such a request does nothing.
// - Code in Block 0 targets Block 1, code in Block 1 targets Block 0.
// - Strap high, bank 00: high code programs low Block 1; low code programs Block 0.
// - Strap high, bank nonzero: low targets program Block 1, high targets do nothing.
// - External code, bank 00 splits by address; nonzero bank always programs Block 0.
// - Bank select overlays Block 1 on the lowest 8 KByte, making it reachable.
// - Hidden code cannot be an origin; a hidden block is still programmable.
// - Chip erase clears both blocks and is accepted only with strap low.
// - Chip erase is refused at lock level 4 and otherwise clears locks.
// - Block erase from external code picks Block 0 or Block 1 from the bank-select field.
// - Timing oscillator runs only while a flash operation needs it.
// - Sequencer and core both run on the external system clock.
// - Fetching continues from the other block or outside during an operation.
// - Identify returns the maker code at 30H and the part code at 31H.
// - Busy flag at status bit 2 holds while running and drops when ready.
// - Sector erase clears 128 bytes chosen by the high and low address.
// - Command bit 7 raises the external interrupt-one request at completion.
module iaf_mailbox (
  // Clock, reset and clock enable.
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Fetch context of the issuing code.
  input  wire logic                  external_fetch_strap,
  input  wire logic                  fetch_external,
  input  wire logic [15:0]           fetch_pc,
  // Security state.
  input  wire logic [1:0]            block_lock,
  input  wire logic                  lock_level4,
  // Flash array side.
  output logic                       flash_start,
  output iaf_pkg::iaf_flash_req_s    flash_req,
  input  wire logic                  flash_done,
  output logic                       osc_en,
  output logic                       lock_clear,
  // Completion interrupt.
  output logic                       ext_interrupt_one
);
  // Register state.
  iaf_pkg::iaf_state_e state_reg, state_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  addr_low_reg;
  logic [7:0]  addr_high_reg;
  logic [7:0]  data_reg;
  logic [7:0]  config_reg;
  logic        refused_reg;
  logic [31:0] prdata_reg;
  logic        irq_reg;
  logic        start_reg;
  logic        clear_reg;
  logic        osc_reg;
  iaf_pkg::iaf_flash_req_s req_reg;
  logic        tgt_blk;
  logic        tgt_none;
  logic [7:0]  sig_data;

  // APB decode.
  wire acc       = psel & penable;
  wire setup     = psel & ~penable;
  wire hit_stat  = (paddr == iaf_pkg::STATUS_OFS);
  wire hit_cmd   = (paddr == iaf_pkg::CMD_OFS);
  wire hit_al    = (paddr == iaf_pkg::ADDRL_OFS);
  wire hit_ah    = (paddr == iaf_pkg::ADDRH_OFS);
  wire hit_data  = (paddr == iaf_pkg::DATA_OFS);
  wire hit_cfg   = (paddr == iaf_pkg::CONFIG_OFS);
  wire mapped    = hit_stat | hit_cmd | hit_al | hit_ah | hit_data | hit_cfg;
  wire wr        = ce & acc & pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Command decode.
  wire        busy      = (state_reg != iaf_pkg::ST_IDLE);
  wire        cmd_wr    = wr & hit_cmd & ~busy;
  wire [6:0]  code      = pwdata[6:0];
  wire        is_chip   = (code == iaf_pkg::CMD_CHIP_ERASE);
  wire        is_block  = (code == iaf_pkg::CMD_BLOCK_ERASE);
  wire        is_sector = (code == iaf_pkg::CMD_SECTOR_ERASE);
  wire        is_prog   = (code == iaf_pkg::CMD_BYTE_PROG);
  wire        is_id     = (code == iaf_pkg::CMD_IDENTIFY);
  wire        is_ep     = is_chip | is_block | is_sector | is_prog;
  wire [1:0]  bank_sel  = config_reg[iaf_pkg::CFG_BANK_LSB +: 2];
  wire        enabled   = config_reg[iaf_pkg::CFG_ENABLE_BIT];
  wire [15:0] mbox_addr = {addr_high_reg, addr_low_reg};

  // Block erase probes the block that the bank field makes visible low.
  wire [15:0] probe_addr = (bank_sel == 2'h0) ? iaf_pkg::BLOCK1_PROBE
                                              : iaf_pkg::BLOCK1_LIMIT;
  wire [15:0] res_addr   = is_block ? probe_addr : mbox_addr;

  // Target resolution from fetch origin, strap and bank select.
  iaf_target_resolve u_resolve (
    .strap          (external_fetch_strap),
    .fetch_external (fetch_external),
    .fetch_pc       (fetch_pc),
    .bank_sel       (bank_sel),
    .target_addr    (res_addr),
    .target_blk     (tgt_blk),
    .no_op          (tgt_none)
  );

  // Acceptance checks for the command being written.
  wire locked    = block_lock[tgt_blk];
  wire chip_ok   = ~external_fetch_strap & ~lock_level4;
  wire blk_ok    = ~tgt_none & ~locked;
  wire accept_op = cmd_wr & is_ep & enabled & (is_chip ? chip_ok : blk_ok);
  wire accept_id = cmd_wr & is_id;
  wire refuse    = cmd_wr & ~accept_op & ~accept_id;

  // Operation type of the accepted command.
  wire iaf_pkg::iaf_op_e op_sel = is_chip   ? iaf_pkg::OP_CHIP   :
                                  is_block  ? iaf_pkg::OP_BLOCK  :
                                  is_sector ? iaf_pkg::OP_SECTOR :
                                  is_prog   ? iaf_pkg::OP_PROG   :
                                  iaf_pkg::OP_NONE;

  // Sector erase aligns the address down to a 128-byte sector.
  wire [15:0] req_addr = is_sector ?
                         {mbox_addr[15:iaf_pkg::SECTOR_BITS], {iaf_pkg::SECTOR_BITS{1'b0}}}
                         : mbox_addr;

  // Signature store for the identify command.
  iaf_sig_rom u_sig (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .rd_en   (accept_id),
    .addr    (addr_low_reg),
    .rd_data (sig_data)
  );

  // Completion events of the two running states.
  wire run_done = (state_reg == iaf_pkg::ST_RUN) & flash_done;
  wire id_done  = (state_reg == iaf_pkg::ST_IDENT);
  wire finish   = run_done | id_done;

  // Next state of the sequencer.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      iaf_pkg::ST_IDLE:
      begin
        if (accept_op)
          state_next = iaf_pkg::ST_RUN;
        else if (accept_id)
          state_next = iaf_pkg::ST_IDENT;
      end
      iaf_pkg::ST_RUN:
      begin
        if (flash_done)
          state_next = iaf_pkg::ST_IDLE;
      end
      iaf_pkg::ST_IDENT:
        state_next = iaf_pkg::ST_IDLE;
      default:
        state_next = iaf_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state; the core keeps fetching, nothing here stalls it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= iaf_pkg::ST_IDLE;
    else if (ce)
      state_reg <= state_next;
  end

  // Mailbox registers written by software.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_reg       <= iaf_pkg::REG_RST;
      addr_low_reg  <= iaf_pkg::REG_RST;
      addr_high_reg <= iaf_pkg::REG_RST;
      config_reg    <= iaf_pkg::REG_RST;
    end
    else
    begin
      if (cmd_wr)
        cmd_reg <= pwdata[7:0];
      if (wr && hit_al)
        addr_low_reg <= pwdata[7:0];
      if (wr && hit_ah)
        addr_high_reg <= pwdata[7:0];
      if (wr && hit_cfg)
        config_reg <= pwdata[7:0];
    end
  end

  // Data register; the identify result wins over a software write.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_reg <= iaf_pkg::REG_RST;
    else if (ce && id_done)
      data_reg <= sig_data;
    else if (wr && hit_data)
      data_reg <= pwdata[7:0];
  end

  // Sticky refused flag; a new refusal wins over a write-one clear.
  wire refused_clr = wr & hit_stat & pwdata[iaf_pkg::STAT_REFUSED_BIT];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      refused_reg <= 1'b0;
    else if (ce)
      refused_reg <= refuse | (refused_reg & ~refused_clr);
  end

  // Flash request, start pulse and oscillator gate.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_reg   <= '0;
      start_reg <= 1'b0;
      osc_reg   <= 1'b0;
    end
    else if (ce)
    begin
      start_reg <= accept_op;
      if (accept_op)
        req_reg <= '{op: op_sel, blk: tgt_blk, addr: req_addr, data: data_reg};
      if (accept_op)
        osc_reg <= 1'b1;
      else if (run_done)
        osc_reg <= 1'b0;
    end
  end

  // Completion pulses: interrupt request and lock clear after chip erase.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_reg   <= 1'b0;
      clear_reg <= 1'b0;
    end
    else if (ce)
    begin
      irq_reg   <= finish & cmd_reg[iaf_pkg::CMD_IRQ_BIT];
      clear_reg <= run_done & (req_reg.op == iaf_pkg::OP_CHIP);
    end
  end

  // Read data captured in the setup phase, ready in the access phase.
  wire [7:0] status_val = {5'h00, busy, 1'b0, refused_reg};
  wire [7:0] rd_byte    = hit_stat ? status_val    :
                          hit_cmd  ? cmd_reg       :
                          hit_al   ? addr_low_reg  :
                          hit_ah   ? addr_high_reg :
                          hit_data ? data_reg      :
                          hit_cfg  ? config_reg    : 8'h00;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_reg <= 32'h00000000;
    else if (ce && setup)
      prdata_reg <= {24'h000000, rd_byte};
  end

  // Output drive.
  assign prdata            = prdata_reg;
  assign flash_start       = start_reg;
  assign flash_req         = req_reg;
  assign osc_en            = osc_reg;
  assign lock_clear        = clear_reg;
  assign ext_interrupt_one = irq_reg;

  // Checks on the sequencer.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  disabled_ignore_a: assert property (cmd_wr && is_ep && !enabled |=> !flash_start && !busy)
    else $error("Command started while programming is disabled.");
  start_cmd_a: assert property (accept_op |=> flash_start && busy && osc_en)
    else $error("Accepted command did not start the flash.");
  locked_block_a: assert property (cmd_wr && is_ep && !is_chip && locked |=> !flash_start)
    else $error("Command reached a locked block.");
  same_block_a: assert property (cmd_wr && !is_chip && tgt_none |=> !flash_start)
    else $error("Originating block was targeted.");
  int_origin_a: assert property (accept_op && !is_chip && external_fetch_strap && !fetch_external
      && bank_sel == 2'h0 && fetch_pc < iaf_pkg::BLOCK1_LIMIT |=> flash_req.blk == 1'b0)
    else $error("Block 1 code did not target Block 0.");
  chip_strap_a: assert property (cmd_wr && is_chip && (external_fetch_strap || lock_level4)
      |=> !flash_start)
    else $error("Chip erase accepted against strap or lock level.");
  osc_gate_a: assert property (run_done && ce |=> !osc_en ##1 (!osc_en || busy))
    else $error("Oscillator left running after completion.");
  busy_hold_a: assert property (ce && state_reg == iaf_pkg::ST_RUN
      |=> busy == !$past(flash_done))
    else $error("Busy flag wrong while the flash runs.");
  irq_done_a: assert property (finish && ce && cmd_reg[iaf_pkg::CMD_IRQ_BIT]
      |=> ext_interrupt_one ##1 !ext_interrupt_one || finish)
    else $error("Completion interrupt missing.");
  refused_quiet_a: assert property (refuse |=> !busy && !ext_interrupt_one && refused_reg)
    else $error("Ignored command raised busy or interrupt.");
  // A started operation must show busy, and the request must only move on a new command.
  busy_start_a: assert property (flash_start |-> busy)
    else $error("Flash started without the busy flag.");
  req_hold_a: assert property (!accept_op |=> $stable(flash_req))
    else $error("Flash request changed without a command.");
  // Completion pulses only follow the completion that causes them.
  lock_clear_a: assert property ($rose(lock_clear)
      |-> $past(run_done && req_reg.op == iaf_pkg::OP_CHIP))
    else $error("Lock clear pulse without a completed chip erase.");
  irq_cause_a: assert property ($rose(ext_interrupt_one) |-> $past(finish))
    else $error("Completion interrupt without a completion.");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench of the flash mailbox sequencer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("BAD at %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module tb;
  // Clock, reset and bus signals.
  logic                    clk;
  logic                    rst;
  logic                    ce;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  // Fetch context, security state and flash side.
  logic                    strap;
  logic                    fext;
  logic [15:0]             pc;
  logic [1:0]              lock;
  logic                    lvl4;
  logic                    fdone;
  logic                    fstart;
  logic                    osc_en;
  logic                    lock_clear;
  logic                    irq;
  iaf_pkg::iaf_flash_req_s req;
  // Bookkeeping of the bench.
  int                      err_count;
  int                      checks;
  logic [31:0]             rd;
  logic                    err;
  logic [7:0]              dv;

  // The device under test; the bench drives the clock enable.
  iaf_mailbox dut (
    .clk(clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_fetch_strap(strap), .fetch_external(fext), .fetch_pc(pc),
    .block_lock(lock), .lock_level4(lvl4),
    .flash_start(fstart), .flash_req(req), .flash_done(fdone),
    .osc_en(osc_en), .lock_clear(lock_clear), .ext_interrupt_one(irq)
  );

  // Free-running 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write and register read with comparison.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp)
  endtask

  // Sets the fetch context and loads the mailbox registers.
  task automatic setup(input logic s, input logic e, input logic [15:0] p,
                       input logic [1:0] bank, input logic en,
                       input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    strap <= s;
    fext  <= e;
    pc    <= p;
    dv = d;
    wr(iaf_pkg::CONFIG_OFS, {25'h0, en, 4'h0, bank});
    wr(iaf_pkg::ADDRH_OFS, {24'h0, a[15:8]});
    wr(iaf_pkg::ADDRL_OFS, {24'h0, a[7:0]});
    wr(iaf_pkg::DATA_OFS, {24'h0, d});
  endtask

  // Issues a command and judges acceptance, the request and completion.
  task automatic run(input logic [6:0] code, input logic ib, input logic ok,
                     input iaf_pkg::iaf_op_e op, input logic blk, input logic [15:0] a);
    wr(iaf_pkg::CMD_OFS, {24'h0, ib, code});
    #1;
    `CHK(fstart, ok)
    `CHK(osc_en, ok)
    if (ok)
    begin
      `CHK(req.op, op)
      if (op != iaf_pkg::OP_CHIP)
        `CHK(req.blk, blk)
      if (op == iaf_pkg::OP_PROG || op == iaf_pkg::OP_SECTOR)
        `CHK(req.addr, a)
      if (op == iaf_pkg::OP_PROG)
        `CHK(req.data, dv)
      rdc(iaf_pkg::STATUS_OFS, 32'h0000_0004);
      @(posedge clk);
      fdone <= 1'b1;
      @(posedge clk);
      fdone <= 1'b0;
      #1;
      `CHK(irq, ib)
      `CHK(lock_clear, op == iaf_pkg::OP_CHIP)
      `CHK(osc_en, 1'b0)
      rdc(iaf_pkg::STATUS_OFS, 32'h0000_0000);
    end
    else
    begin
      rdc(iaf_pkg::STATUS_OFS, 32'h0000_0001);
      wr(iaf_pkg::STATUS_OFS, 32'h0000_0001);
    end
  endtask

  // Reset values, read-back and an unmapped address.
  task automatic t_regs();
    for (int i = 0; i < 6; i++)
      rdc(8'(i * 4), 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHK(err, 1'b1)
    `CHK(pready, 1'b1)
    wr(iaf_pkg::DATA_OFS, 32'h0000_00A5);
    rdc(iaf_pkg::DATA_OFS, 32'h0000_00A5);
  endtask

  // A write while the clock enable is low must leave the register untouched.
  task automatic t_freeze();
    ce <= 1'b0;
    wr(iaf_pkg::DATA_OFS, 32'h0000_003C);
    ce <= 1'b1;
    rdc(iaf_pkg::DATA_OFS, 32'h0000_00A5);
  endtask

  // Address resolution across strap, bank select and origin.
  task automatic t_table();
    setup(1'b1, 1'b0, 16'h4000, 2'b00, 1'b0, 16'h0100, 8'h3C);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b0, iaf_pkg::OP_PROG, 1'b1, 16'h0100);
    setup(1'b1, 1'b0, 16'h4000, 2'b00, 1'b1, 16'h0100, 8'h3C);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b1, 1'b1, iaf_pkg::OP_PROG, 1'b1, 16'h0100);
    setup(1'b1, 1'b0, 16'h4000, 2'b00, 1'b1, 16'h4100, 8'h5C);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b0, iaf_pkg::OP_PROG, 1'b0, 16'h4100);
    setup(1'b1, 1'b0, 16'h1000, 2'b00, 1'b1, 16'h4100, 8'h6D);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b1, iaf_pkg::OP_PROG, 1'b0, 16'h4100);
    setup(1'b1, 1'b0, 16'h0100, 2'b01, 1'b1, 16'h4100, 8'h11);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b0, iaf_pkg::OP_PROG, 1'b0, 16'h4100);
    setup(1'b1, 1'b0, 16'h0100, 2'b10, 1'b1, 16'h0100, 8'h22);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b1, 1'b1, iaf_pkg::OP_PROG, 1'b1, 16'h0100);
    setup(1'b0, 1'b0, 16'h0000, 2'b00, 1'b1, 16'h4100, 8'h33);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b1, iaf_pkg::OP_PROG, 1'b0, 16'h4100);
    setup(1'b0, 1'b0, 16'h0000, 2'b00, 1'b1, 16'h0100, 8'h44);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b1, iaf_pkg::OP_PROG, 1'b1, 16'h0100);
    setup(1'b1, 1'b1, 16'h0000, 2'b11, 1'b1, 16'h0100, 8'h55);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b1, iaf_pkg::OP_PROG, 1'b0, 16'h0100);
  endtask

  // Locks, chip erase, block erase and sector erase.
  task automatic t_erase();
    lock <= 2'b10;
    setup(1'b1, 1'b0, 16'h4000, 2'b00, 1'b1, 16'h0100, 8'h3C);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b0, iaf_pkg::OP_PROG, 1'b1, 16'h0100);
    run(iaf_pkg::CMD_CHIP_ERASE, 1'b0, 1'b0, iaf_pkg::OP_CHIP, 1'b0, 16'h0000);
    setup(1'b0, 1'b0, 16'h0000, 2'b00, 1'b1, 16'h0000, 8'h55);
    lvl4 <= 1'b1;
    run(iaf_pkg::CMD_CHIP_ERASE, 1'b0, 1'b0, iaf_pkg::OP_CHIP, 1'b0, 16'h0000);
    lvl4 <= 1'b0;
    run(iaf_pkg::CMD_CHIP_ERASE, 1'b1, 1'b1, iaf_pkg::OP_CHIP, 1'b0, 16'h0000);
    lock <= 2'b00;
    run(iaf_pkg::CMD_BLOCK_ERASE, 1'b0, 1'b1, iaf_pkg::OP_BLOCK, 1'b1, 16'h0000);
    setup(1'b0, 1'b0, 16'h0000, 2'b01, 1'b1, 16'h12FF, 8'h55);
    run(iaf_pkg::CMD_BLOCK_ERASE, 1'b0, 1'b1, iaf_pkg::OP_BLOCK, 1'b0, 16'h0000);
    setup(1'b0, 1'b0, 16'h0000, 2'b00, 1'b1, 16'h12FF, 8'h55);
    run(iaf_pkg::CMD_SECTOR_ERASE, 1'b0, 1'b1, iaf_pkg::OP_SECTOR, 1'b1, 16'h1280);
    run(iaf_pkg::CMD_BYTE_PROG, 1'b0, 1'b1, iaf_pkg::OP_PROG, 1'b1, 16'h12FF);
  endtask

  // Signature reads through the identify command.
  task automatic t_ident();
    setup(1'b1, 1'b0, 16'h4000, 2'b00, 1'b0, 16'h0030, 8'h00);
    wr(iaf_pkg::CMD_OFS, 32'h0000_008F);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    rdc(iaf_pkg::DATA_OFS, 32'h0000_005A);
    wr(iaf_pkg::ADDRL_OFS, 32'h0000_0031);
    wr(iaf_pkg::CMD_OFS, 32'h0000_000F);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    rdc(iaf_pkg::DATA_OFS, 32'h0000_00A5);
  endtask

  // Main sequence: reset, then the scenarios.
  initial
  begin
    err_count = 0;
    checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    strap = 1'b0;
    fext = 1'b0;
    pc = 16'h0000;
    lock = 2'b00;
    lvl4 = 1'b0;
    fdone = 1'b0;
    ce = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_freeze();
    t_table();
    t_erase();
    t_ident();
    give_verdict();
  end

  // Watchdog that cuts a hang short.
  initial
  begin
    #500000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
